// ===== hw/l2lru_replace.v
// replacement state and valid bits for a 4-way second-level cache
`timescale 1ns/1ps
`include "l2lru_consts.vh"
// What this block does
// R1: four ways per set, per-set state names the least recently used way
// R2: cpu hit with no same-cycle allocation marks the hitting way of the indexed set most recent
// R3: allocation with no invalid way evicts the least recently used way
// R4: allocation takes an invalid way first, before the recency state
// R5: cpu program or data access to mapped ram leaves recency untouched
// R6: dma access to mapped ram never changes any set's recency state
// R7: recency stored in groups of four consecutive sets
// R8: hit update writes only the accessed set, not its three neighbours
// R9: mapped ram addresses index sets exactly like external addresses
// R10: four consecutive sets span 512 bytes of address
// R11: block invalidate and writeback-invalidate clear lines for reuse
// R12: after reset all lines invalid, each set holds a fixed ordering
// R13: a newly allocated way becomes most recent in its set
module l2lru_replace
#(
  parameter SETS  = `L2LRU_SETS,
  parameter SET_W = `L2LRU_SET_W
)
(
  // clock, reset, enable
  input  wire                     clk_i,
  input  wire                     resetn_i,
  input  wire                     ce_i,
  // access lookup: hit way comes from the tag compare
  input  wire                     acc_valid_i,
  input  wire [`L2LRU_ADDR_W-1:0] acc_addr_i,
  input  wire [1:0]               acc_src_i,
  input  wire                     acc_ram_i,
  input  wire                     acc_hit_i,
  input  wire [`L2LRU_WAY_W-1:0]  acc_way_i,
  // allocation request
  input  wire                     alloc_valid_i,
  input  wire [`L2LRU_ADDR_W-1:0] alloc_addr_i,
  output wire                     alloc_ready_o,
  output reg                      alloc_done_o,
  output reg  [`L2LRU_WAY_W-1:0]  alloc_way_o,
  output reg                      alloc_evict_o,
  // block invalidate, one line per request
  input  wire                     inv_valid_i,
  input  wire [`L2LRU_ADDR_W-1:0] inv_addr_i,
  input  wire [`L2LRU_WAY_W-1:0]  inv_way_i,
  input  wire                     inv_wb_i,
  output reg                      inv_done_o,
  output reg                      inv_wb_o,
  // status of the last allocated set; set_lru_o also follows hits
  output reg  [`L2LRU_WAYS-1:0]   set_valid_o,
  output reg  [`L2LRU_WAY_W-1:0]  set_lru_o
);
  localparam GROUPS = SETS / `L2LRU_GROUP_SETS;
  localparam GRP_W  = SET_W - 2;

  reg rst_q1;
  reg rst_q2;
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  wire rst_n = rst_q2;

  // four sets' orderings share one group word, written per set lane
  reg [4*`L2LRU_AGE_W-1:0] age_mem [0:GROUPS-1]; // see R7
  reg [`L2LRU_WAYS-1:0]    vld_mem [0:SETS-1];

  // the same index bits whether the address is ram or external memory
  wire [SET_W-1:0] acc_set   =
    acc_addr_i[`L2LRU_LINE_LSB +: SET_W];   // see R9 see R10
  wire [SET_W-1:0] alloc_set =
    alloc_addr_i[`L2LRU_LINE_LSB +: SET_W]; // see R9
  wire [SET_W-1:0] inv_set   =
    inv_addr_i[`L2LRU_LINE_LSB +: SET_W];

  // clear sweep after reset: one set per cycle
  localparam ST_CLEAR = 3'b001;
  localparam ST_RUN   = 3'b010;
  localparam ST_IDLE  = 3'b100;
  reg [2:0]       state;
  reg [2:0]       next_state;
  reg [SET_W-1:0] clr_idx;
  always @*
  begin
    case (state)
      ST_CLEAR: next_state = (clr_idx == SETS - 1) ? ST_RUN : ST_CLEAR;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_CLEAR;
    endcase
  end
  wire running = (state == ST_RUN);
  assign alloc_ready_o = running;

  // hits update only cpu accesses to cache; ram and dma are ignored
  wire hit_upd = running && acc_valid_i && acc_hit_i && !acc_ram_i &&
                 (acc_src_i != `L2LRU_SRC_DMA); // see R5 see R6
  // allocation has priority for the update port over a same-cycle hit
  wire do_alloc = running && alloc_valid_i;
  wire do_inv   = running && inv_valid_i;
  wire do_hit   = hit_upd && !do_alloc;

  wire [SET_W-1:0] upd_set = do_alloc ? alloc_set : acc_set;
  wire [GRP_W-1:0] upd_grp = upd_set[SET_W-1:2];
  wire [1:0]       upd_lane = upd_set[1:0];
  wire [4*`L2LRU_AGE_W-1:0] grp_word = age_mem[upd_grp];
  wire [`L2LRU_AGE_W-1:0]   cur_age  = grp_word[upd_lane*8 +: 8];
  wire [`L2LRU_WAYS-1:0]    cur_vld  = vld_mem[alloc_set];

  // invalid way first, lowest number wins; else the oldest way
  reg                    has_inv;
  reg [`L2LRU_WAY_W-1:0] inv_pick;
  integer k;
  always @*
  begin
    has_inv  = 1'b0;
    inv_pick = 2'h0;
    for (k = `L2LRU_WAYS - 1; k >= 0; k = k - 1)
      if (!cur_vld[k])
      begin
        has_inv  = 1'b1;
        inv_pick = k[1:0];
      end
  end

  wire [`L2LRU_AGE_W-1:0] probe_age;
  wire [`L2LRU_WAY_W-1:0] lru_way;
  l2lru_age_update u_probe
  (
    .age_i     (cur_age),
    .way_i     (2'h0),
    .age_o     (),
    .lru_way_o (lru_way)
  );
  assign probe_age = cur_age;

  wire [`L2LRU_WAY_W-1:0] victim =
    has_inv ? inv_pick : lru_way; // see R3 see R4
  wire [`L2LRU_WAY_W-1:0] used_way = do_alloc ? victim : acc_way_i;

  wire [`L2LRU_AGE_W-1:0] new_age;
  l2lru_age_update u_upd
  (
    .age_i     (probe_age),
    .way_i     (used_way),
    .age_o     (new_age),
    .lru_way_o ()
  ); // see R2 see R13

  integer s;
  integer g;
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= ST_IDLE;
      clr_idx       <= {SET_W{1'b0}};
      alloc_done_o  <= 1'b0;
      alloc_way_o   <= 2'h0;
      alloc_evict_o <= 1'b0;
      inv_done_o    <= 1'b0;
      inv_wb_o      <= 1'b0;
      set_valid_o   <= 4'h0;
      set_lru_o     <= 2'h0;
    end
    else if (ce_i)
    begin
      state        <= next_state;
      alloc_done_o <= 1'b0;
      inv_done_o   <= 1'b0;
      if (state == ST_CLEAR)
        clr_idx <= clr_idx + {{(SET_W-1){1'b0}}, 1'b1};
      if (do_alloc || do_hit)
        set_lru_o <= lru_way;
      if (do_alloc)
      begin
        alloc_done_o  <= 1'b1;
        alloc_way_o   <= victim;
        alloc_evict_o <= !has_inv;
        set_valid_o   <= cur_vld | (4'h1 << victim);
      end
      if (do_inv)
      begin
        inv_done_o <= 1'b1;
        inv_wb_o   <= inv_wb_i;
      end
    end
  end

  // memories carry no reset: the clear sweep gives them start values,
  // which keeps the arrays out of the asynchronous reset tree
  always @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (state == ST_CLEAR)
      begin
        // every line invalid and a fixed ordering per set
        vld_mem[clr_idx] <= 4'h0; // see R12
        age_mem[clr_idx[SET_W-1:2]][clr_idx[1:0]*8 +: 8] <=
          `L2LRU_AGE_RESET;
      end
      if (do_alloc || do_hit)
      begin
        // only this set's lane of the group word is written
        age_mem[upd_grp][upd_lane*8 +: 8] <= new_age; // see R8
      end
      // invalidate wins over an allocation into the same line
      if (do_inv)
      begin
        if (do_alloc && alloc_set == inv_set)
          vld_mem[inv_set] <=
            (cur_vld | (4'h1 << victim)) & ~(4'h1 << inv_way_i);
        else
          vld_mem[inv_set] <=
            vld_mem[inv_set] & ~(4'h1 << inv_way_i); // see R11
        if (do_alloc && alloc_set != inv_set)
          vld_mem[alloc_set] <= cur_vld | (4'h1 << victim);
      end
      else if (do_alloc)
        vld_mem[alloc_set] <= cur_vld | (4'h1 << victim);
    end
  end
  // see R1: four ranks per set held in age_mem, decoded by u_probe
endmodule // l2lru_replace

// ===== hw/l2lru_consts.vh
// constants for the second-level cache replacement-state block
`ifndef L2LRU_CONSTS_VH
`define L2LRU_CONSTS_VH
`define L2LRU_WAYS         4
`define L2LRU_WAY_W        2
`define L2LRU_SETS         64
`define L2LRU_SET_W        6
`define L2LRU_GROUP_SETS   4
`define L2LRU_GROUP_BYTES  512
`define L2LRU_LINE_LSB     7
`define L2LRU_ADDR_W       32
`define L2LRU_AGE_W        8
`define L2LRU_AGE_RESET    8'h1B
`define L2LRU_SRC_PROG     2'h0
`define L2LRU_SRC_DATA     2'h1
`define L2LRU_SRC_DMA      2'h2
`endif

// ===== hw/l2lru_age_update.v
// age-vector update for one set: chosen way becomes most recent
`timescale 1ns/1ps
`include "l2lru_consts.vh"
module l2lru_age_update
(
  // current ordering and way that was used
  input  wire [`L2LRU_AGE_W-1:0] age_i,
  input  wire [`L2LRU_WAY_W-1:0] way_i,
  // new ordering and the way used longest ago
  output reg  [`L2LRU_AGE_W-1:0] age_o,
  output reg  [`L2LRU_WAY_W-1:0] lru_way_o
);
  // each way has a 2-bit rank: 0 most recent, 3 least recent
  integer w;
  reg [1:0] rank_used;
  reg [1:0] rank_w;
  always @*
  begin
    rank_used = age_i[way_i*2 +: 2];
    age_o     = age_i;
    lru_way_o = 2'h0;
    for (w = 0; w < `L2LRU_WAYS; w = w + 1)
    begin
      rank_w = age_i[w*2 +: 2];
      if (rank_w == 2'h3)
        lru_way_o = w[1:0];
      if (w[1:0] == way_i)
        age_o[w*2 +: 2] = 2'h0;
      else if (rank_w < rank_used)
        age_o[w*2 +: 2] = rank_w + 2'h1;
    end
  end
endmodule // l2lru_age_update

// ===== verif/l2lru_chk.sv
// assertions on the ports of the replacement-state block
`timescale 1ns/1ps
module l2lru_chk
#(
  parameter SETS  = 64,
  parameter SET_W = 6
)
(
  input wire       clk_i,
  input wire       resetn_i,
  input wire       ce_i,
  input wire       alloc_valid_i,
  input wire       inv_valid_i,
  input wire       inv_wb_i,
  input wire       alloc_ready_o,
  input wire       alloc_done_o,
  input wire       alloc_evict_o,
  input wire       inv_done_o,
  input wire       inv_wb_o,
  input wire [1:0] alloc_way_o,
  input wire [1:0] set_lru_o,
  input wire [3:0] set_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire       take_a = ce_i && alloc_ready_o && alloc_valid_i;
  wire       take_i = ce_i && alloc_ready_o && inv_valid_i;
  // ways 0 up to the chosen one
  wire [3:0] low    = (4'h2 << alloc_way_o) - 4'h1;

  AST_ALLOC_ANS: assert property (take_a |=> alloc_done_o)
    else $error("allocation not answered");
  AST_ALLOC_IDLE: assert property (!take_a |=> !alloc_done_o)
    else $error("allocation answer without request");
  AST_EVICT_LRU: assert property (alloc_done_o && alloc_evict_o |->
    alloc_way_o == set_lru_o && set_valid_o == 4'hF)
    else $error("eviction not from least recent way");
  AST_LOW_INVALID: assert property (alloc_done_o && !alloc_evict_o |->
    (set_valid_o & low) == low)
    else $error("invalid way not lowest free");
  AST_FILL_VALID: assert property (alloc_done_o |-> set_valid_o[alloc_way_o])
    else $error("allocated way not valid");
  AST_INV_ANS: assert property (take_i |=>
    inv_done_o && inv_wb_o == $past(inv_wb_i))
    else $error("invalidate not answered");
  AST_INV_IDLE: assert property (!take_i |=> !inv_done_o)
    else $error("invalidate answer without request");
  AST_RST_CLEAR: assert property ($rose(resetn_i) |-> !alloc_ready_o [*8])
    else $error("ready before clear sweep");
  AST_HOLD: assert property (!alloc_done_o |->
    $stable(alloc_way_o) && $stable(alloc_evict_o))
    else $error("allocation result moved");
  cover property (alloc_done_o && alloc_evict_o);
  cover property (alloc_done_o && !alloc_evict_o);
  cover property (inv_done_o && inv_wb_o);
endmodule // l2lru_chk

bind l2lru_replace l2lru_chk #(.SETS(SETS), .SET_W(SET_W)) i_chk (.*);

// ===== verif/l2lru_cpu_model.sv
// fetch-path and dma stand-in: one access per request
`timescale 1ns/1ps
module l2lru_cpu_model
(
  // request from the bench
  input  wire        clk_i,
  input  wire        go_i,
  input  wire [31:0] addr_i,
  input  wire [1:0]  src_i,
  input  wire        ram_i,
  input  wire [1:0]  way_i,
  // access toward the block
  output reg         acc_valid_o = 1'b0,
  output reg         acc_hit_o = 1'b0,
  output reg  [31:0] acc_addr_o = 32'h0000_0000,
  output reg  [1:0]  acc_src_o = 2'h0,
  output reg         acc_ram_o = 1'b0,
  output reg  [1:0]  acc_way_o = 2'h0
);
  // idle address flips so a stale value never looks like a live one
  always @(posedge clk_i)
  begin
    acc_valid_o <= go_i;
    acc_hit_o   <= go_i;
    acc_addr_o  <= go_i ? addr_i : ~acc_addr_o;
    acc_src_o   <= src_i;
    acc_ram_o   <= ram_i;
    acc_way_o   <= way_i;
  end
endmodule // l2lru_cpu_model

// ===== verif/tb_l2lru_replace.sv
// self-checking bench for the replacement-state block
`timescale 1ns/1ps
module tb_l2lru_replace;
  typedef struct {logic [1:0] k; logic [5:0] s; logic [1:0] w;
    logic [1:0] src; logic r; logic [1:0] ew; logic ev;} l2lru_row_t;
  // k: 0 hit, 1 allocate, 2 invalidate (ev then is the writeback flag)
  l2lru_row_t rows [16] = '{'{1,5,0,0,0,0,0}, '{1,5,0,0,0,1,0},
    '{1,5,0,0,0,2,0}, '{1,5,0,0,0,3,0}, '{1,5,0,0,0,0,1},
    '{0,5,1,0,0,0,0}, '{0,5,2,1,0,0,0}, '{0,5,3,0,0,0,0},
    '{0,5,2,0,1,0,0}, '{0,5,1,1,1,0,0}, '{0,5,2,2,1,0,0},
    '{0,4,0,0,0,0,0}, '{1,5,0,0,0,0,1}, '{2,5,3,0,0,0,1},
    '{1,5,0,0,0,3,0}, '{1,5,0,0,0,1,1}};
  reg        clk_i = 0, resetn_i = 0, ce_i = 1, go = 0, ram = 0;
  reg        alloc_valid_i = 0, inv_valid_i = 0, inv_wb_i = 0;
  reg [31:0] addr = 32'h0000_0000;
  reg [1:0]  way = 2'h0, src = 2'h0;
  wire [31:0] alloc_addr_i = addr, inv_addr_i = addr, acc_addr_i;
  wire [1:0]  inv_way_i = way, acc_src_i, acc_way_i, alloc_way_o, set_lru_o;
  wire        acc_valid_i, acc_ram_i, acc_hit_i, alloc_ready_o, alloc_done_o;
  wire        alloc_evict_o, inv_done_o, inv_wb_o;
  wire [3:0]  set_valid_o;
  int         failures = 0, n_checks = 0, cyc = 0, i;

  l2lru_replace i_dut (.*);
  l2lru_cpu_model i_cpu (.clk_i(clk_i), .go_i(go), .addr_i(addr),
    .src_i(src), .ram_i(ram), .way_i(way), .acc_valid_o(acc_valid_i),
    .acc_hit_o(acc_hit_i), .acc_addr_o(acc_addr_i), .acc_src_o(acc_src_i),
    .acc_ram_o(acc_ram_i), .acc_way_o(acc_way_i));

  always #2 clk_i = ~clk_i;

  task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ready stays low through the clear sweep, so wait on it with a bound
  task rst;
    @(posedge clk_i);
    resetn_i <= 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1;
    @(negedge clk_i);
    chk("ready_early", alloc_ready_o, 0);
    for (i = 0; i < 200 && alloc_ready_o !== 1'b1; i++) @(posedge clk_i);
    chk("ready", alloc_ready_o, 1);
  endtask

  task op(input l2lru_row_t r);
    @(posedge clk_i);
    addr <= {19'h0, r.s, 7'h0};
    way <= r.w;
    src <= r.src;
    ram <= r.r;
    inv_wb_i <= r.ev;
    go <= (r.k == 0);
    alloc_valid_i <= (r.k == 1);
    inv_valid_i <= (r.k == 2);
    @(posedge clk_i);
    go <= 0;
    alloc_valid_i <= 0;
    inv_valid_i <= 0;
    addr <= ~addr;
    @(negedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      tally_and_finish;
    end
  end

  initial
  begin
    rst;
    foreach (rows[j])
    begin
      op(rows[j]);
      if (rows[j].k == 1)
      begin
        chk("alloc_done", alloc_done_o, 1);
        chk("alloc_way", alloc_way_o, rows[j].ew);
        chk("alloc_evict", alloc_evict_o, rows[j].ev);
      end
      if (rows[j].k == 2)
      begin
        chk("inv_done", inv_done_o, 1);
        chk("inv_wb", inv_wb_o, rows[j].ev);
      end
    end
    $display("table test done");
    rst;
    op('{1,5,0,0,0,0,0});
    chk("rst_way", alloc_way_o, 0);
    chk("rst_evict", alloc_evict_o, 0);
    $display("reset test done");
    @(posedge clk_i);
    addr <= 32'h0000_0480;
    alloc_valid_i <= 1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("b2b_first", alloc_way_o, 0);
    @(posedge clk_i);
    alloc_valid_i <= 0;
    @(negedge clk_i);
    chk("b2b_second", alloc_way_o, 1);
    $display("back to back test done");
    @(posedge clk_i);
    ce_i <= 0;
    alloc_valid_i <= 1;
    repeat (2) @(posedge clk_i);
    ce_i <= 1;
    alloc_valid_i <= 0;
    @(negedge clk_i);
    chk("ce_frozen", alloc_done_o, 0);
    chk("ce_hold", alloc_way_o, 1);
    $display("clock enable test done");
    tally_and_finish;
  end
endmodule // tb_l2lru_replace
